// file: design/mmp_pkg.sv
package mmp_pkg;

    // core clock rate
    localparam int CLK_MHZ = 10;

    // phy reset pulse length after core reset or a request
    localparam int PHY_RST_TIME_US = 10;
    localparam int PHY_RST_CYC     = PHY_RST_TIME_US * CLK_MHZ;

    // indicator stretch after a nibble was seen
    localparam int ACT_HOLD_TIME_US = 200;
    localparam int ACT_HOLD_CYC     = ACT_HOLD_TIME_US * CLK_MHZ;

    // management clock half period, least time rounded up
    localparam int MDC_HALF_NS  = 500;
    localparam int MDC_HALF_CYC = (MDC_HALF_NS * CLK_MHZ + 999) / 1000;

    // management frame layout
    localparam int MDIO_FRAME_BITS = 64;
    localparam int MDIO_TA_BIT     = 46;
    localparam int MDIO_DATA_BIT   = 48;
    localparam logic [31:0] MDIO_PREAMBLE = 32'hffffffff;
    localparam logic [1:0]  MDIO_START    = 2'h1;
    localparam logic [1:0]  MDIO_OP_READ  = 2'h2;
    localparam logic [1:0]  MDIO_OP_WRITE = 2'h1;
    localparam logic [1:0]  MDIO_TA_WRITE = 2'h2;

    // indicator modes
    localparam logic [1:0] IND_ACT_SPEED   = 2'h0;
    localparam logic [1:0] IND_ACT_DUPLEX  = 2'h1;
    localparam logic [1:0] IND_TX_RX       = 2'h2;
    localparam logic [1:0] IND_ACT_BY_RATE = 2'h3;
    localparam logic [2:0] IND_ALL_OFF     = 3'h7;

    // synchroniser width for all pins that come from the phy
    localparam int SYNC_W = 12;

endpackage

// file: design/mmp_sync.sv
`timescale 1ns/1ps
module mmp_sync #(
    parameter int W = mmp_pkg::SYNC_W
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] async,
    output logic      [W-1:0] synced
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] synced_nxt;

    // first stage feeds only the second stage
    always_comb begin
        meta_nxt   = async;
        synced_nxt = meta_r;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_r <= '0;
            synced <= '0;
        end else begin
            meta_r <= meta_nxt;
            synced <= synced_nxt;
        end
    end
endmodule // mmp_sync

// file: design/mmp_mdio.sv
`timescale 1ns/1ps
module mmp_mdio (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        start,
    input  wire logic        readOp,
    input  wire logic [4:0]  phyAddr,
    input  wire logic [4:0]  regAddr,
    input  wire logic [15:0] wrData,
    input  wire logic        mdioIn,
    output logic             busy,
    output logic             done,
    output logic      [15:0] rdData,
    output logic             mdc,
    output logic             mdioOut,
    output logic             mdioOe
);
    typedef enum logic [1:0] {
        MD_IDLE = 2'b01,
        MD_RUN  = 2'b10
    } mmp_mdio_state_t;

    mmp_mdio_state_t state_r, state_nxt;
    logic [2:0]  div_r, div_nxt;
    logic [6:0]  bit_r, bit_nxt;
    logic [63:0] shift_r, shift_nxt;
    logic [15:0] rd_r, rd_nxt;
    logic        read_r, read_nxt;
    logic        mdc_r, mdc_nxt;
    logic        done_r, done_nxt;

    // frame sequencer: data moves on the falling clock edge
    always_comb begin
        state_nxt = state_r;
        div_nxt   = div_r;
        bit_nxt   = bit_r;
        shift_nxt = shift_r;
        rd_nxt    = rd_r;
        read_nxt  = read_r;
        mdc_nxt   = mdc_r;
        done_nxt  = 1'b0;
        unique case (state_r)
            MD_IDLE: begin
                mdc_nxt = 1'b0;
                if (start) begin
                    shift_nxt = {mmp_pkg::MDIO_PREAMBLE, mmp_pkg::MDIO_START,
                                 readOp ? mmp_pkg::MDIO_OP_READ
                                        : mmp_pkg::MDIO_OP_WRITE,
                                 phyAddr, regAddr, mmp_pkg::MDIO_TA_WRITE,
                                 wrData};
                    read_nxt  = readOp;
                    bit_nxt   = 7'h00;
                    div_nxt   = 3'h0;
                    state_nxt = MD_RUN;
                end
            end
            MD_RUN: begin
                if (div_r == 3'(mmp_pkg::MDC_HALF_CYC - 1)) begin
                    div_nxt = 3'h0;
                    mdc_nxt = ~mdc_r;
                    if (mdc_r) begin
                        // end of high phase: take read bit, move on
                        if (read_r && bit_r >= 7'(mmp_pkg::MDIO_DATA_BIT))
                            rd_nxt = {rd_r[14:0], mdioIn};
                        shift_nxt = {shift_r[62:0], 1'b0};
                        bit_nxt   = bit_r + 7'h01;
                        if (bit_r == 7'(mmp_pkg::MDIO_FRAME_BITS - 1)) begin
                            state_nxt = MD_IDLE;
                            done_nxt  = 1'b1;
                        end
                    end
                end else begin
                    div_nxt = div_r + 3'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r <= MD_IDLE;
            div_r   <= 3'h0;
            bit_r   <= 7'h00;
            shift_r <= 64'h0;
            rd_r    <= 16'h0000;
            read_r  <= 1'b0;
            mdc_r   <= 1'b0;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            div_r   <= div_nxt;
            bit_r   <= bit_nxt;
            shift_r <= shift_nxt;
            rd_r    <= rd_nxt;
            read_r  <= read_nxt;
            mdc_r   <= mdc_nxt;
            done_r  <= done_nxt;
        end
    end

    // line released from turnaround onward on reads
    assign busy    = (state_r == MD_RUN);
    assign mdc     = mdc_r;
    assign mdioOut = shift_r[63];
    assign mdioOe  = busy && !(read_r &&
                     bit_r >= 7'(mmp_pkg::MDIO_TA_BIT));
    assign done    = done_r;
    assign rdData  = rd_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_mdio_release: assert property (
        busy && read_r && bit_r >= 7'd46 |-> !mdioOe)
        else $error("management line driven during read data");
    chk_mdc_half_period: assert property (
        $rose(mdc) |=> mdc [*4] ##1 !mdc)
        else $error("management clock high phase wrong length");
    chk_frame_preamble: assert property (
        state_r == MD_IDLE && start |=> mdioOut && mdioOe && !mdc [*5])
        else $error("frame does not open with driven preamble");
endmodule // mmp_mdio

// file: design/mmp_port.sv
`timescale 1ns/1ps
module mmp_port (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        phyTxClk,
    output logic      [3:0]  phyTxData,
    output logic             phyTxEnable,
    input  wire logic        phyRxClk,
    input  wire logic [3:0]  phyRxData,
    input  wire logic        phyRxDataValid,
    input  wire logic        phyRxError,
    input  wire logic        phyCollision,
    output logic             mgmtClock,
    input  wire logic        mgmtDataIn,
    output logic             mgmtDataOut,
    output logic             mgmtDataOe,
    input  wire logic        phyLinkStatus,
    input  wire logic        phyActiveStatus,
    output logic             phy_power_on_reset_n,
    output logic      [2:0]  indicatorN,
    input  wire logic [1:0]  indicator_mode_select,
    input  wire logic        indicator_off_in_power_down,
    input  wire logic        powerDown,
    input  wire logic        speed100,
    input  wire logic        fullDuplex,
    input  wire logic        phyResetRequest,
    input  wire logic [3:0]  txNibble,
    input  wire logic        txValid,
    output logic             txReady,
    output logic      [3:0]  rxNibble,
    output logic             rxValid,
    output logic             rxError,
    output logic             rxEnd,
    output logic             collision,
    output logic             linkUp,
    input  wire logic        mgmtStart,
    input  wire logic        mgmtRead,
    input  wire logic [4:0]  mgmtPhyAddr,
    input  wire logic [4:0]  mgmtRegAddr,
    input  wire logic [15:0] mgmtWrData,
    output logic             mgmtBusy,
    output logic             mgmtDone,
    output logic      [15:0] mgmtRdData
);
    logic [11:0] pinSync;
    logic        txClkS, rxClkS, rxDvS, rxErS, colS, linkS, actS, mdioS;
    logic [3:0]  rxdS;

    // every phy pin passes two flops before use
    mmp_sync #(.W(mmp_pkg::SYNC_W)) u_sync (
        .clk    (clk),
        .nrst   (nrst),
        .async  ({phyTxClk, phyRxClk, phyRxData, phyRxDataValid,
                  phyRxError, phyCollision, phyLinkStatus,
                  phyActiveStatus, mgmtDataIn}),
        .synced (pinSync)
    );
    assign {txClkS, rxClkS, rxdS, rxDvS, rxErS, colS, linkS, actS,
            mdioS} = pinSync;

    // clock edge finders
    logic txClkPrev_r, txClkPrev_nxt;
    logic rxClkPrev_r, rxClkPrev_nxt;
    logic txClkRise, rxClkRise;

    always_comb begin
        txClkPrev_nxt = txClkS;
        rxClkPrev_nxt = rxClkS;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            txClkPrev_r <= 1'b0;
            rxClkPrev_r <= 1'b0;
        end else begin
            txClkPrev_r <= txClkPrev_nxt;
            rxClkPrev_r <= rxClkPrev_nxt;
        end
    end

    assign txClkRise = txClkS && !txClkPrev_r;
    assign rxClkRise = rxClkS && !rxClkPrev_r;

    // transmit path: one nibble taken per transmit clock rise
    logic [3:0] txd_r, txd_nxt;
    logic       txEn_r, txEn_nxt;

    always_comb begin
        txd_nxt  = txd_r;
        txEn_nxt = txEn_r;
        if (txClkRise) begin
            txEn_nxt = txValid;
            txd_nxt  = txValid ? txNibble : 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            txd_r  <= 4'h0;
            txEn_r <= 1'b0;
        end else begin
            txd_r  <= txd_nxt;
            txEn_r <= txEn_nxt;
        end
    end

    assign txReady     = txClkRise;
    assign phyTxData   = txd_r;
    assign phyTxEnable = txEn_r;

    // receive path: nibble, valid and error taken on receive clock rise
    logic [3:0] rxNib_r, rxNib_nxt;
    logic       rxVal_r, rxVal_nxt;
    logic       rxErr_r, rxErr_nxt;
    logic       rxEnd_r, rxEnd_nxt;
    logic       rxDvPrev_r, rxDvPrev_nxt;

    always_comb begin
        rxNib_nxt    = rxNib_r;
        rxVal_nxt    = 1'b0;
        rxErr_nxt    = 1'b0;
        rxEnd_nxt    = 1'b0;
        rxDvPrev_nxt = rxDvPrev_r;
        if (rxClkRise) begin
            rxDvPrev_nxt = rxDvS;
            rxVal_nxt    = rxDvS;
            if (rxDvS)
                rxNib_nxt = rxdS;
            rxErr_nxt = rxErS;
            rxEnd_nxt = rxDvPrev_r && !rxDvS;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rxNib_r    <= 4'h0;
            rxVal_r    <= 1'b0;
            rxErr_r    <= 1'b0;
            rxEnd_r    <= 1'b0;
            rxDvPrev_r <= 1'b0;
        end else begin
            rxNib_r    <= rxNib_nxt;
            rxVal_r    <= rxVal_nxt;
            rxErr_r    <= rxErr_nxt;
            rxEnd_r    <= rxEnd_nxt;
            rxDvPrev_r <= rxDvPrev_nxt;
        end
    end

    assign rxNibble = rxNib_r;
    assign rxValid  = rxVal_r;
    assign rxError  = rxErr_r;
    assign rxEnd    = rxEnd_r;

    // collision level as is, link level with selectable polarity
    logic col_r, col_nxt;
    logic link_r, link_nxt;

    always_comb begin
        col_nxt  = colS;
        link_nxt = actS ? !linkS : linkS;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            col_r  <= 1'b0;
            link_r <= 1'b0;
        end else begin
            col_r  <= col_nxt;
            link_r <= link_nxt;
        end
    end

    assign collision = col_r;
    assign linkUp    = link_r;

    // phy reset: held low a fixed time after core reset or a request
    logic [6:0] rstCnt_r, rstCnt_nxt;
    logic       phyRstN_r, phyRstN_nxt;

    always_comb begin
        rstCnt_nxt  = rstCnt_r;
        phyRstN_nxt = 1'b0;
        if (phyResetRequest)
            rstCnt_nxt = 7'h00;
        else if (rstCnt_r != 7'(mmp_pkg::PHY_RST_CYC))
            rstCnt_nxt = rstCnt_r + 7'h01;
        else
            phyRstN_nxt = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rstCnt_r  <= 7'h00;
            phyRstN_r <= 1'b0;
        end else begin
            rstCnt_r  <= rstCnt_nxt;
            phyRstN_r <= phyRstN_nxt;
        end
    end

    assign phy_power_on_reset_n = phyRstN_r;

    // activity stretchers so short bursts stay visible
    logic [10:0] txAct_r, txAct_nxt;
    logic [10:0] rxAct_r, rxAct_nxt;
    logic [2:0]  ind_r, ind_nxt;
    logic        txAct, rxAct, anyAct;

    assign txAct  = (txAct_r != 11'h000);
    assign rxAct  = (rxAct_r != 11'h000);
    assign anyAct = txAct || rxAct;

    // indicator pattern per mode, active low on the pins
    always_comb begin
        txAct_nxt = txAct ? txAct_r - 11'h001 : txAct_r;
        rxAct_nxt = rxAct ? rxAct_r - 11'h001 : rxAct_r;
        if (txClkRise && txEn_r)
            txAct_nxt = 11'(mmp_pkg::ACT_HOLD_CYC);
        if (rxClkRise && rxDvS)
            rxAct_nxt = 11'(mmp_pkg::ACT_HOLD_CYC);
        unique case (indicator_mode_select)
            mmp_pkg::IND_ACT_SPEED:
                ind_nxt = ~{link_r && !speed100, link_r && speed100, anyAct};
            mmp_pkg::IND_ACT_DUPLEX:
                ind_nxt = ~{fullDuplex, link_r, anyAct};
            mmp_pkg::IND_TX_RX:
                ind_nxt = ~{rxAct, link_r, txAct};
            mmp_pkg::IND_ACT_BY_RATE:
                ind_nxt = ~{fullDuplex, anyAct && link_r && speed100,
                            anyAct && link_r && !speed100};
        endcase
        if (powerDown && indicator_off_in_power_down)
            ind_nxt = mmp_pkg::IND_ALL_OFF;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            txAct_r <= 11'h000;
            rxAct_r <= 11'h000;
            ind_r   <= mmp_pkg::IND_ALL_OFF;
        end else begin
            txAct_r <= txAct_nxt;
            rxAct_r <= rxAct_nxt;
            ind_r   <= ind_nxt;
        end
    end

    assign indicatorN = ind_r;

    // management master
    mmp_mdio u_mdio (
        .clk     (clk),
        .nrst    (nrst),
        .start   (mgmtStart),
        .readOp  (mgmtRead),
        .phyAddr (mgmtPhyAddr),
        .regAddr (mgmtRegAddr),
        .wrData  (mgmtWrData),
        .mdioIn  (mdioS),
        .busy    (mgmtBusy),
        .done    (mgmtDone),
        .rdData  (mgmtRdData),
        .mdc     (mgmtClock),
        .mdioOut (mgmtDataOut),
        .mdioOe  (mgmtDataOe)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence txTake;
        txClkRise && txValid;
    endsequence

    sequence txHold;
        phyTxEnable && !txClkRise [*1];
    endsequence

    chk_tx_enable_data: assert property (
        txTake |=> phyTxEnable && phyTxData == $past(txNibble))
        else $error("valid nibble not driven with enable");
    chk_tx_idle_low: assert property (
        txClkRise && !txValid |=> !phyTxEnable && phyTxData == 4'h0)
        else $error("enable high without a valid nibble");
    chk_tx_nibble_stable: assert property (
        txHold |=> $stable(phyTxData))
        else $error("transmit nibble moved between clock rises");
    chk_rx_nibble_capture: assert property (
        rxClkRise && rxDvS |=> rxValid && rxNibble == $past(rxdS))
        else $error("received nibble not captured");
    chk_rx_error_short: assert property (
        rxClkRise && rxErS |=> rxError ##1 !rxError)
        else $error("one-cycle receive error missed");
    chk_link_polarity: assert property (
        ##1 linkUp == ($past(actS) ? !$past(linkS) : $past(linkS)))
        else $error("link polarity select ignored");
    chk_phy_reset_hold: assert property (
        phyResetRequest |=> !phy_power_on_reset_n [*8])
        else $error("phy reset released too early");
    chk_indicator_blank: assert property (
        powerDown && indicator_off_in_power_down |=> indicatorN == 3'h7)
        else $error("indicators lit in power down");
    chk_indicator_link: assert property (
        indicator_mode_select == 2'h1 && link_r && !powerDown
        |=> !indicatorN[1])
        else $error("link indicator off with link up");
endmodule // mmp_port

// file: verif/mmp_phy_model.sv
`timescale 1ns/1ps
// behavioural phy: link clocks, receive frames, management slave
module mmp_phy_model (
    output logic       phyTxClk,
    output logic       phyRxClk,
    output logic [3:0] phyRxData,
    output logic       phyRxDataValid,
    output logic       phyRxError,
    input  wire logic  mgmtClock,
    input  wire logic  mgmtDataOut,
    input  wire logic  mgmtDataOe,
    output logic       mgmtDataIn
);
    logic [63:0] frame;
    logic [63:0] lastFrame;
    logic [15:0] regVal;
    logic [6:0]  cnt;
    logic        isRd;
    logic        drv;
    logic        drvBit;

    // free running clocks, phase unrelated to the core clock
    initial begin
        phyTxClk = 1'b0;
        #53;
        forever #400 phyTxClk = ~phyTxClk;
    end
    initial begin
        phyRxClk = 1'b0;
        #137;
        forever #400 phyRxClk = ~phyRxClk;
    end
    initial begin
        phyRxData = 4'h0;
        phyRxDataValid = 1'b0;
        phyRxError = 1'b0;
        frame = 64'h0;
        cnt = 7'h0;
        isRd = 1'b0;
        drv = 1'b0;
        regVal = 16'h0;
    end

    // line level: device, else phy, else the pull-up
    assign mgmtDataIn = mgmtDataOe ? mgmtDataOut : (drv ? drvBit : 1'b1);

    // shift in one bit per rising management clock, 64 bits a frame
    always @(posedge mgmtClock) begin
        frame = {frame[62:0], mgmtDataIn};
        cnt = cnt + 7'h1;
        if (cnt == 7'h40) begin
            cnt = 7'h0;
            lastFrame = frame;
            if (frame[29:28] == mmp_pkg::MDIO_OP_WRITE)
                regVal = frame[15:0];
        end
    end

    // read answer: zero in second turnaround bit, then data msb first
    always @(negedge mgmtClock) begin
        if (cnt == 7'h2f)
            isRd = (frame[12:11] == mmp_pkg::MDIO_OP_READ);
        drv = isRd && cnt >= 7'h2f;
        drvBit = (cnt == 7'h2f) ? 1'b0 : regVal[7'h3f - cnt];
    end

    // one nibble per receive clock, changed on the falling edge
    task automatic rxNib(input logic [3:0] n, input logic err);
        @(negedge phyRxClk);
        phyRxData = n;
        phyRxDataValid = 1'b1;
        phyRxError = err;
    endtask

    // end of packet: valid drops, data no longer shows the last nibble
    task automatic rxStop();
        @(negedge phyRxClk);
        phyRxDataValid = 1'b0;
        phyRxError = 1'b0;
        phyRxData = ~phyRxData;
    endtask
endmodule // mmp_phy_model

// file: verif/mmp_port_tb.sv
`timescale 1ns/1ps
module mmp_port_tb;
    logic        clk, nrst, phyTxClk, phyTxEnable, phyRxClk;
    logic        phyRxDataValid, phyRxError, phyCollision, mgmtClock;
    logic        mgmtDataIn, mgmtDataOut, mgmtDataOe, phyLinkStatus;
    logic        phyActiveStatus, phy_power_on_reset_n, powerDown;
    logic        indicator_off_in_power_down, speed100, fullDuplex;
    logic        phyResetRequest, txValid, txReady, rxValid, rxError;
    logic        rxEnd, collision, linkUp, mgmtStart, mgmtRead;
    logic        mgmtBusy, mgmtDone;
    logic [1:0]  indicator_mode_select;
    logic [2:0]  indicatorN;
    logic [3:0]  phyTxData, phyRxData, txNibble, rxNibble, nb;
    logic [4:0]  mgmtPhyAddr, mgmtRegAddr;
    logic [15:0] mgmtWrData, mgmtRdData, wd;
    logic [16:0] me;
    logic [3:0]  txq[$];
    logic [4:0]  rxq[$];
    logic [16:0] mgq[$];
    logic [2:0]  expInd[4] = '{3'h5, 3'h1, 3'h5, 3'h3};
    int          err_total, n_tests, seed, n, i, nEnd;

    // core clock
    initial clk = 1'b0;
    always #50 clk = ~clk;

    mmp_port uut (.clk, .nrst, .phyTxClk, .phyTxData, .phyTxEnable,
        .phyRxClk, .phyRxData, .phyRxDataValid, .phyRxError, .phyCollision,
        .mgmtClock, .mgmtDataIn, .mgmtDataOut, .mgmtDataOe, .phyLinkStatus,
        .phyActiveStatus, .phy_power_on_reset_n, .indicatorN,
        .indicator_mode_select, .indicator_off_in_power_down, .powerDown,
        .speed100, .fullDuplex, .phyResetRequest, .txNibble, .txValid,
        .txReady, .rxNibble, .rxValid, .rxError, .rxEnd, .collision,
        .linkUp, .mgmtStart, .mgmtRead, .mgmtPhyAddr, .mgmtRegAddr,
        .mgmtWrData, .mgmtBusy, .mgmtDone, .mgmtRdData);

    mmp_phy_model phy (.phyTxClk, .phyRxClk, .phyRxData, .phyRxDataValid,
        .phyRxError, .mgmtClock, .mgmtDataOut, .mgmtDataOe, .mgmtDataIn);

    // compare one result, count it, report a mismatch
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp,
                       input string what);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // wait k edges, then step just past the edge
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // count edges until the phy reset output goes high
    task automatic rstLen();
        n = 0;
        while (phy_power_on_reset_n !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        cmp(n inside {[100:103]}, 1, "phy reset length");
    endtask

    // hold a nibble until taken, then note it for the line watcher
    task automatic txSend(input logic [3:0] d);
        txNibble = d;
        txValid = 1'b1;
        n = 0;
        // ready is looked at while settled, the next edge takes the nibble
        while (txReady !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        cmp(n < 40, 1, "tx taken");
        @(posedge clk);
        #1;
        txq.push_back(d);
    endtask

    // one management frame; a start while busy must be ignored
    task automatic mgmt(input logic rd);
        if (!rd)
            wd = $random(seed);
        mgmtRead = rd;
        mgmtWrData = rd ? ~wd : wd;
        mgmtPhyAddr = $random(seed);
        mgmtRegAddr = $random(seed);
        mgmtStart = 1'b1;
        mgq.push_back({rd, wd});
        tick(1);
        mgmtStart = 1'b0;
        tick(50);
        mgmtStart = 1'b1;
        mgmtRead = ~rd;
        tick(1);
        mgmtStart = 1'b0;
        mgmtRead = rd;
        n = 51;
        while (mgmtDone !== 1'b1 && n < 900) begin
            @(posedge clk);
            #1;
            n++;
        end
        cmp(n inside {[640:642]}, 1, "mgmt length");
        cmp(phy.lastFrame[63:18], {mmp_pkg::MDIO_PREAMBLE,
            mmp_pkg::MDIO_START, rd ? mmp_pkg::MDIO_OP_READ :
            mmp_pkg::MDIO_OP_WRITE, mgmtPhyAddr, mgmtRegAddr}, "frame");
        if (!rd)
            cmp(phy.lastFrame[17:0], {mmp_pkg::MDIO_TA_WRITE, wd}, "wr");
        tick(3);
    endtask

    // result watchers: oldest note against each result as it appears
    always @(posedge phyTxClk)
        if (phyTxEnable === 1'b1)
            cmp(phyTxData, txq.size() ? txq.pop_front() : 'x, "tx");
    always @(negedge clk) begin
        if (rxValid === 1'b1)
            cmp({rxError, rxNibble}, rxq.size() ? rxq.pop_front() : 'x,
                "rx");
        if (rxEnd === 1'b1)
            nEnd++;
        if (mgmtDone === 1'b1) begin
            me = mgq.size() ? mgq.pop_front() : 'x;
            if (me[16] !== 1'b0)
                cmp(mgmtRdData, me[15:0], "rd");
        end
    end

    // watchdog
    initial begin
        #(20000 * 100);
        err_total++;
        $display("ERROR %0t timeout", $time);
        results();
    end

    // main sequence
    initial begin
        seed = 32'h7c10f436;
        {err_total, n_tests, nEnd} = 0;
        {nrst, txValid, txNibble, mgmtStart, mgmtRead} = 0;
        {mgmtPhyAddr, mgmtRegAddr, mgmtWrData, phyCollision} = 0;
        {powerDown, indicator_off_in_power_down, phyResetRequest} = 0;
        {phyActiveStatus, phyLinkStatus, speed100, fullDuplex} = 4'hf;
        indicator_mode_select = mmp_pkg::IND_TX_RX;
        repeat (12) @(posedge clk);
        cmp({phy_power_on_reset_n, indicatorN, phyTxEnable, mgmtDataOe},
            6'h1c, "reset");
        #1;
        nrst = 1'b1;
        rstLen();
        phyResetRequest = 1'b1;
        tick(3);
        cmp(phy_power_on_reset_n, 0, "reset req");
        phyResetRequest = 1'b0;
        rstLen();
        for (i = 0; i < 6; i++)
            txSend($random(seed));
        txValid = 1'b0;
        tick(20);
        cmp({txq.size(), phyTxEnable, indicatorN[0]}, 2'h0, "tx end");
        for (i = 0; i < 5; i++) begin
            nb = $random(seed);
            rxq.push_back({i == 2, nb});
            phy.rxNib(nb, i == 2);
        end
        phy.rxStop();
        tick(10);
        cmp({rxq.size(), nEnd[7:0], indicatorN[2]}, 41'h2, "rx end");
        phyCollision = 1'b1;
        tick(6);
        cmp(collision, 1, "coll on");
        phyCollision = 1'b0;
        tick(6);
        cmp(collision, 0, "coll off");
        for (i = 0; i < 4; i++) begin
            {phyActiveStatus, phyLinkStatus} = i[1:0];
            tick(6);
            cmp(linkUp, i[1] ^ i[0], "link");
        end
        phyActiveStatus = 1'b0;
        tick(mmp_pkg::ACT_HOLD_CYC + 20);
        for (i = 0; i < 4; i++) begin
            indicator_mode_select = i[1:0];
            tick(3);
            cmp(indicatorN, expInd[i], "lamps");
        end
        indicator_mode_select = mmp_pkg::IND_ACT_SPEED;
        speed100 = 1'b0;
        powerDown = 1'b1;
        tick(3);
        cmp(indicatorN, 3'h3, "lamps 10");
        indicator_off_in_power_down = 1'b1;
        tick(3);
        cmp(indicatorN, mmp_pkg::IND_ALL_OFF, "blank");
        mgmt(1'b0);
        mgmt(1'b1);
        cmp(mgq.size(), 0, "mgmt done");
        results();
    end
endmodule // mmp_port_tb
